// *** bench/flash_write_control_status_test.sv ***
module flash_write_control_status_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  fwcs_pkg::fwcs_reg_req_s req = '0;
  logic [15:0] rdata;
  logic rvalid;
  logic rtrap;
  logic bank_rd = 1'b0;
  logic bank_wr = 1'b0;
  logic [31:0] bank_addr = 32'h00000000;
  logic bank_rd_ok;
  logic bank_wr_ok;
  logic bank_trap;
  fwcs_pkg::fwcs_arr_cmd_s arr_cmd;
  logic arr_go;
  logic arr_resume;
  logic arr_suspend;
  logic arr_done = 1'b0;
  logic arr_fail = 1'b0;
  logic boot = 1'b0;
  logic test_vis;
  int err_total = 0;
  int compares = 0;

  always #5 clk = ~clk;

  fwcs_ctrl u_fwcs_ctrl (
    .REF_CLK(clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .REG_TRAP(rtrap), .BANK_RD(bank_rd), .BANK_WR(bank_wr), .BANK_ADDR(bank_addr),
    .BANK_RD_OK(bank_rd_ok), .BANK_WR_OK(bank_wr_ok), .BANK_TRAP(bank_trap),
    .ARR_CMD(arr_cmd), .ARR_GO(arr_go), .ARR_RESUME(arr_resume), .ARR_SUSPEND(arr_suspend),
    .ARR_DONE(arr_done), .ARR_FAIL(arr_fail), .BOOT_MODE_PIN(boot), .TEST_AREA_VIS(test_vis)
  );

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.be <= be;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // The read answer is registered on the taking edge; four waited cycles mean a hang.
  task automatic rd(input logic [4:0] a, input logic [15:0] msk, input logic [15:0] exp,
                    input logic trp);
    int n;
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    n = 0;
    #1;
    while (rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 4) begin
      err_total++;
      test_done();
    end
    chk(64'(rdata & msk), 64'(exp));
    chk(64'(rtrap), 64'(trp));
  endtask

  // Writes the command half and checks the three launch pulses one cycle later.
  task automatic cmd(input logic [15:0] d, input logic go, input logic res, input logic sus);
    wr(5'h02, 2'b10, d);
    #1;
    chk(64'({arr_go, arr_resume, arr_suspend}), 64'({go, res, sus}));
  endtask

  task automatic done(input logic f);
    @(posedge clk);
    arr_done <= 1'b1;
    arr_fail <= f;
    @(posedge clk);
    arr_done <= 1'b0;
    arr_fail <= 1'b0;
  endtask

  task automatic bank(input logic r, input logic w, input logic [31:0] a, input logic ok,
                      input logic trp);
    @(posedge clk);
    bank_rd <= r;
    bank_wr <= w;
    bank_addr <= a;
    #1;
    chk(64'(r ? bank_rd_ok : bank_wr_ok), 64'(ok));
    @(posedge clk);
    bank_rd <= 1'b0;
    bank_wr <= 1'b0;
    #1;
    chk(64'(bank_trap), 64'(trp));
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(5'h00, 16'hFFFF, 16'h0000, 1'b0);
    rd(5'h02, 16'hFFFF, 16'h0000, 1'b0);
    rd(5'h1E, 16'hFFFF, 16'h0000, 1'b0);
    wr(5'h08, 2'b11, 16'h1234);
    wr(5'h0A, 2'b11, 16'h5678);
    wr(5'h0C, 2'b11, 16'h9ABC);
    wr(5'h0E, 2'b11, 16'hDEF0);
    wr(5'h10, 2'b11, 16'h0000);
    wr(5'h12, 2'b11, 16'h0001);
    cmd(16'hA000, 1'b1, 1'b0, 1'b0);
    chk(64'(arr_cmd.sel), 64'(fwcs_pkg::SEL_WPG));
    chk(64'(arr_cmd.addr), 64'h10000);
    rd(5'h00, 16'hFFFF, 16'h0010, 1'b0);
    rd(5'h08, 16'hFFFF, 16'hFFFF, 1'b1);
    rd(5'h14, 16'hFFFF, 16'hFFFF, 1'b1);
    wr(5'h08, 2'b11, 16'hAAAA);
    bank(1'b1, 1'b0, 32'h10000, 1'b0, 1'b1);
    bank(1'b0, 1'b1, 32'h10000, 1'b0, 1'b0);
    done(1'b0);
    rd(5'h00, 16'hFFFF, 16'h0000, 1'b0);
    rd(5'h02, 16'hFFFF, 16'h0000, 1'b0);
    rd(5'h08, 16'hFFFF, 16'h1234, 1'b0);
    bank(1'b1, 1'b0, 32'h10000, 1'b1, 1'b0);
    wr(5'h10, 2'b11, 16'h0008);
    cmd(16'h9000, 1'b1, 1'b0, 1'b0);
    chk(arr_cmd.data, 64'hDEF09ABC56781234);
    cmd(16'h4000, 1'b0, 1'b0, 1'b1);
    rd(5'h00, 16'hFFFF, 16'h0000, 1'b0);
    cmd(16'h8800, 1'b0, 1'b0, 1'b0);
    cmd(16'h9000, 1'b0, 1'b1, 1'b0);
    rd(5'h00, 16'hFFFF, 16'h0010, 1'b0);
    done(1'b0);
    wr(5'h14, 2'b11, 16'h0000);
    wr(5'h04, 2'b01, 16'h0003);
    cmd(16'h8800, 1'b1, 1'b0, 1'b0);
    chk(64'(arr_cmd.sect), 64'h03);
    cmd(16'h4000, 1'b0, 1'b0, 1'b1);
    rd(5'h02, 16'h8800, 16'h0800, 1'b0);
    bank(1'b1, 1'b0, 32'h10000, 1'b1, 1'b0);
    cmd(16'hA000, 1'b1, 1'b0, 1'b0);
    cmd(16'h4000, 1'b0, 1'b0, 1'b0);
    done(1'b0);
    cmd(16'h8800, 1'b0, 1'b1, 1'b0);
    done(1'b0);
    rd(5'h04, 16'h00FF, 16'h0000, 1'b0);
    cmd(16'hA000, 1'b1, 1'b0, 1'b0);
    done(1'b1);
    rd(5'h00, 16'hFFFF, 16'h0000, 1'b0);
    rd(5'h14, 16'h0001, 16'h0001, 1'b0);
    cmd(16'hA000, 1'b0, 1'b0, 1'b0);
    wr(5'h14, 2'b11, 16'h0000);
    cmd(16'h8100, 1'b0, 1'b0, 1'b0);
    rd(5'h14, 16'h0002, 16'h0002, 1'b0);
    wr(5'h14, 2'b11, 16'h0000);
    wr(5'h10, 2'b11, 16'hDFBF);
    wr(5'h12, 2'b11, 16'h0008);
    cmd(16'h8100, 1'b1, 1'b0, 1'b0);
    bank(1'b1, 1'b0, 32'h10000, 1'b0, 1'b1);
    done(1'b0);
    bank(1'b0, 1'b1, 32'h00000100, 1'b0, 1'b0);
    bank(1'b1, 1'b0, 32'h00000100, 1'b0, 1'b1);
    @(posedge clk);
    boot <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(64'(test_vis), 64'h1);
    bank(1'b1, 1'b0, 32'h00000100, 1'b1, 1'b0);
    test_done();
  end
endmodule

// *** rtl/fwcs_access_guard.sv ***
module fwcs_access_guard (
  // Register request
  input wire fwcs_pkg::fwcs_reg_req_s req,
  // Controller flags
  input wire logic lock,
  input wire logic busy,
  input wire logic boot,
  // Bank request
  input wire logic bank_rd,
  input wire logic bank_wr,
  input wire logic [31:0] bank_addr,
  // Verdicts
  output logic reg_wr_ok,
  output logic reg_trap,
  output logic bank_rd_ok,
  output logic bank_wr_ok,
  output logic bank_trap
);
  logic mapped;
  logic test_hit;

  assign mapped = (req.addr <= fwcs_pkg::OFS_ERR_L) && !req.addr[0];
  // The lock flag half stays readable so software can poll it.
  assign reg_trap = req.rd && lock && mapped && (req.addr != fwcs_pkg::OFS_CTL0_L);
  assign reg_wr_ok = req.wr && !lock && mapped;
  assign test_hit = bank_addr <= fwcs_pkg::TEST_HI;
  assign bank_trap = bank_rd && (busy || (test_hit && !boot));
  assign bank_rd_ok = bank_rd && !bank_trap;
  assign bank_wr_ok = bank_wr && !busy && !test_hit;
endmodule

// *** rtl/fwcs_ctrl.sv ***
module fwcs_ctrl (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Register port
  input wire fwcs_pkg::fwcs_reg_req_s REG_REQ,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  output logic REG_TRAP,
  // Bank access port
  input wire logic BANK_RD,
  input wire logic BANK_WR,
  input wire logic [31:0] BANK_ADDR,
  output logic BANK_RD_OK,
  output logic BANK_WR_OK,
  output logic BANK_TRAP,
  // Array sequencer
  output fwcs_pkg::fwcs_arr_cmd_s ARR_CMD,
  output logic ARR_GO,
  output logic ARR_RESUME,
  output logic ARR_SUSPEND,
  input wire logic ARR_DONE,
  input wire logic ARR_FAIL,
  // Bootstrap
  input wire logic BOOT_MODE_PIN,
  output logic TEST_AREA_VIS
);

  fwcs_pkg::fwcs_state_e state_ff;
  fwcs_pkg::fwcs_state_e nxt_state;
  logic boot_meta_ff;
  logic boot_ff;
  logic lock_ff;
  logic busy_ff;
  logic wms_ff;
  logic suspend_bit_ff;
  logic [3:0] sel_ff;
  logic [3:0] suspend_bit_sel_ff;
  logic [31:0] dat0_ff;
  logic [31:0] dat1_ff;
  logic [31:0] adr_ff;
  logic err_ff;
  logic sequence_error_flag_ff;
  logic [7:0] sect;
  logic bank_st;
  logic reg_wr_ok;
  logic reg_trap;
  logic bank_trap;
  logic [15:0] wd;
  logic [1:0] be;
  logic wr_ctl_h;
  logic [3:0] req_sel;
  logic start_req;
  logic suspend_bit_req;
  logic done;
  logic suspend_bit_go;
  logic accept;
  logic resume;
  logic refuse;
  logic in_test;
  logic in_prot;
  logic bad_addr;
  logic [15:0] rd_mux;
  logic [15:0] ctl_h;

  function automatic logic [15:0] put16(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] bmask);
    put16 = {bmask[1] ? nw[15:8] : old[15:8], bmask[0] ? nw[7:0] : old[7:0]};
  endfunction

  // The strap pin is asynchronous to the controller clock.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      boot_meta_ff <= 1'b0;
      boot_ff <= 1'b0;
    end else begin
      boot_meta_ff <= BOOT_MODE_PIN;
      boot_ff <= boot_meta_ff;
    end
  end

  assign TEST_AREA_VIS = boot_ff;

  fwcs_access_guard u_guard (
    .req(REG_REQ),
    .lock(lock_ff),
    .busy(busy_ff),
    .boot(boot_ff),
    .bank_rd(BANK_RD),
    .bank_wr(BANK_WR),
    .bank_addr(BANK_ADDR),
    .reg_wr_ok(reg_wr_ok),
    .reg_trap(reg_trap),
    .bank_rd_ok(BANK_RD_OK),
    .bank_wr_ok(BANK_WR_OK),
    .bank_trap(bank_trap)
  );

  assign wd = REG_REQ.wdata;
  assign be = REG_REQ.be;
  assign wr_ctl_h = REG_REQ.wr && (REG_REQ.addr == fwcs_pkg::OFS_CTL0_H) && be[fwcs_pkg::BE_HI];
  assign req_sel = {wd[fwcs_pkg::BIT_WPG], wd[fwcs_pkg::BIT_DOUBLE_WORD_PROGRAM_SELECT],
                    wd[fwcs_pkg::BIT_SER], wd[fwcs_pkg::BIT_SPR]};
  // A start with the error flag high is dropped without setting the sequence error flag; the select bits are still stored.
  assign start_req = wr_ctl_h && reg_wr_ok && wd[fwcs_pkg::BIT_START] && !err_ff;
  // Suspend is the one control write honoured while locked; set protection cannot pause.
  assign suspend_bit_req = wr_ctl_h && wd[fwcs_pkg::BIT_SUSPEND_BIT] && (state_ff == fwcs_pkg::ST_RUN)
                    && ((sel_ff & ~fwcs_pkg::SEL_SPR) != fwcs_pkg::SEL_NONE);
  assign done = ARR_DONE && ((state_ff == fwcs_pkg::ST_RUN) || (state_ff == fwcs_pkg::ST_ESPGM));
  assign suspend_bit_go = suspend_bit_req && !done;

  assign in_test = adr_ff <= fwcs_pkg::TEST_HI;
  assign in_prot = (adr_ff >= fwcs_pkg::PROT_LO) && (adr_ff <= fwcs_pkg::PROT_HI);
  assign bad_addr = (((req_sel & (fwcs_pkg::SEL_WPG | fwcs_pkg::SEL_DOUBLE_WORD_PROGRAM_SELECT)) != 4'h0) && in_test)
                    || ((req_sel == fwcs_pkg::SEL_DOUBLE_WORD_PROGRAM_SELECT) && adr_ff[2])
                    || ((req_sel == fwcs_pkg::SEL_SPR) && !in_prot);

  always_comb begin
    accept = 1'b0;
    resume = 1'b0;
    refuse = 1'b0;
    nxt_state = state_ff;
    if (start_req) begin
      case (state_ff)
        fwcs_pkg::ST_IDLE: begin
          if ($onehot(req_sel) && !bad_addr) begin
            accept = 1'b1;
            nxt_state = fwcs_pkg::ST_RUN;
          end else begin
            refuse = 1'b1;
          end
        end
        fwcs_pkg::ST_SUSPEND_BIT: begin
          if (req_sel == suspend_bit_sel_ff) begin
            resume = 1'b1;
            nxt_state = fwcs_pkg::ST_RUN;
          end else if ((suspend_bit_sel_ff == fwcs_pkg::SEL_SER) && !bad_addr
                       && ((req_sel == fwcs_pkg::SEL_WPG) || (req_sel == fwcs_pkg::SEL_DOUBLE_WORD_PROGRAM_SELECT))) begin
            accept = 1'b1;
            nxt_state = fwcs_pkg::ST_ESPGM;
          end else begin
            refuse = 1'b1;
          end
        end
        default: nxt_state = state_ff;
      endcase
    end else if (done) begin
      nxt_state = (state_ff == fwcs_pkg::ST_ESPGM) ? fwcs_pkg::ST_SUSPEND_BIT : fwcs_pkg::ST_IDLE;
    end else if (suspend_bit_go) begin
      nxt_state = fwcs_pkg::ST_SUSPEND_BIT;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_ff <= fwcs_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Lock, busy and start bit rise together and fall together.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      lock_ff <= 1'b0;
      busy_ff <= 1'b0;
      wms_ff <= 1'b0;
    end else if (accept || resume) begin
      lock_ff <= 1'b1;
      busy_ff <= 1'b1;
      wms_ff <= 1'b1;
    end else if (done || suspend_bit_go) begin
      lock_ff <= 1'b0;
      busy_ff <= 1'b0;
      wms_ff <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      suspend_bit_ff <= 1'b0;
      suspend_bit_sel_ff <= fwcs_pkg::SEL_NONE;
    end else if (suspend_bit_go) begin
      suspend_bit_ff <= 1'b1;
      suspend_bit_sel_ff <= sel_ff;
    end else if (resume) begin
      suspend_bit_ff <= 1'b0;
    end
  end

  // A program run inside an erase suspend hands the erase select back when it ends.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sel_ff <= fwcs_pkg::SEL_NONE;
    end else if (done) begin
      sel_ff <= (state_ff == fwcs_pkg::ST_ESPGM) ? suspend_bit_sel_ff
                                                 : fwcs_pkg::SEL_NONE;
    end else if (wr_ctl_h && reg_wr_ok) begin
      sel_ff <= req_sel;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      dat0_ff <= fwcs_pkg::RST_WORD;
      dat1_ff <= fwcs_pkg::RST_WORD;
      adr_ff <= fwcs_pkg::RST_WORD;
    end else if (reg_wr_ok) begin
      case (REG_REQ.addr)
        fwcs_pkg::OFS_DAT0_L: dat0_ff[15:0] <= put16(dat0_ff[15:0], wd, be);
        fwcs_pkg::OFS_DAT0_H: dat0_ff[31:16] <= put16(dat0_ff[31:16], wd, be);
        fwcs_pkg::OFS_DAT1_L: dat1_ff[15:0] <= put16(dat1_ff[15:0], wd, be);
        fwcs_pkg::OFS_DAT1_H: dat1_ff[31:16] <= put16(dat1_ff[31:16], wd, be);
        fwcs_pkg::OFS_ADR_L: adr_ff[15:0] <= put16(adr_ff[15:0], wd, be);
        fwcs_pkg::OFS_ADR_H: adr_ff[31:16] <= put16(adr_ff[31:16], wd, be);
        default: adr_ff <= adr_ff;
      endcase
    end
  end

  // Array failures land only at the edge where busy drops; hardware set beats a clear.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      err_ff <= 1'b0;
    end else if (done && ARR_FAIL) begin
      err_ff <= 1'b1;
    end else if (reg_wr_ok && (REG_REQ.addr == fwcs_pkg::OFS_ERR_L) && be[fwcs_pkg::BE_LO]) begin
      err_ff <= err_ff & wd[fwcs_pkg::BIT_ERR];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sequence_error_flag_ff <= 1'b0;
    end else if (refuse) begin
      sequence_error_flag_ff <= 1'b1;
    end else if (reg_wr_ok && (REG_REQ.addr == fwcs_pkg::OFS_ERR_L) && be[fwcs_pkg::BE_LO]) begin
      sequence_error_flag_ff <= sequence_error_flag_ff & wd[fwcs_pkg::BIT_SEQUENCE_ERROR_FLAG];
    end
  end

  fwcs_sector_status #(
    .NSECT(8)
  ) u_sect (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .wr_en(reg_wr_ok && (REG_REQ.addr == fwcs_pkg::OFS_SECT_L) && be[fwcs_pkg::BE_LO]),
    .wdata(wd[7:0]),
    .erase_go(accept && (req_sel == fwcs_pkg::SEL_SER)),
    .end_ok(done && !ARR_FAIL && (state_ff == fwcs_pkg::ST_RUN)),
    .sect(sect),
    .bank_st(bank_st)
  );

  // The command is frozen at launch, not at resume, so an erase resumed after a program inside its suspend keeps the program's command.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ARR_CMD <= '0;
    end else if (accept) begin
      ARR_CMD <= {req_sel, adr_ff, dat1_ff, dat0_ff, sect};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ARR_GO <= 1'b0;
      ARR_RESUME <= 1'b0;
      ARR_SUSPEND <= 1'b0;
    end else begin
      ARR_GO <= accept;
      ARR_RESUME <= resume;
      ARR_SUSPEND <= suspend_bit_go;
    end
  end

  always_comb begin
    ctl_h = fwcs_pkg::RST_HALF;
    ctl_h[fwcs_pkg::BIT_START] = wms_ff;
    ctl_h[fwcs_pkg::BIT_SUSPEND_BIT] = suspend_bit_ff;
    ctl_h[fwcs_pkg::BIT_WPG] = sel_ff[3];
    ctl_h[fwcs_pkg::BIT_DOUBLE_WORD_PROGRAM_SELECT] = sel_ff[2];
    ctl_h[fwcs_pkg::BIT_SER] = sel_ff[1];
    ctl_h[fwcs_pkg::BIT_SPR] = sel_ff[0];
    rd_mux = fwcs_pkg::RST_HALF;
    case (REG_REQ.addr)
      fwcs_pkg::OFS_CTL0_L: begin
        rd_mux[fwcs_pkg::BIT_LOCK] = lock_ff;
        rd_mux[fwcs_pkg::BIT_BUSY] = busy_ff && !lock_ff;
      end
      fwcs_pkg::OFS_CTL0_H: rd_mux = ctl_h;
      fwcs_pkg::OFS_SECT_L: rd_mux[7:0] = sect;
      fwcs_pkg::OFS_SECT_H: rd_mux[fwcs_pkg::BIT_BANK_ST] = bank_st;
      fwcs_pkg::OFS_DAT0_L: rd_mux = dat0_ff[15:0];
      fwcs_pkg::OFS_DAT0_H: rd_mux = dat0_ff[31:16];
      fwcs_pkg::OFS_DAT1_L: rd_mux = dat1_ff[15:0];
      fwcs_pkg::OFS_DAT1_H: rd_mux = dat1_ff[31:16];
      fwcs_pkg::OFS_ADR_L: rd_mux = adr_ff[15:0];
      fwcs_pkg::OFS_ADR_H: rd_mux = adr_ff[31:16];
      fwcs_pkg::OFS_ERR_L: begin
        rd_mux[fwcs_pkg::BIT_ERR] = err_ff;
        rd_mux[fwcs_pkg::BIT_SEQUENCE_ERROR_FLAG] = sequence_error_flag_ff;
      end
      default: rd_mux = fwcs_pkg::RST_HALF;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      REG_RDATA <= fwcs_pkg::RST_HALF;
      REG_RVALID <= 1'b0;
      REG_TRAP <= 1'b0;
      BANK_TRAP <= 1'b0;
    end else begin
      REG_RVALID <= REG_REQ.rd;
      REG_TRAP <= reg_trap;
      BANK_TRAP <= bank_trap;
      if (REG_REQ.rd) begin
        REG_RDATA <= reg_trap ? fwcs_pkg::INVALID : rd_mux;
      end
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_launch;
    accept || resume;
  endsequence

  sequence s_halted;
    !busy_ff && !lock_ff && !wms_ff;
  endsequence

  AST_START_LOCK: assert property (s_launch |=> lock_ff && wms_ff && ARR_GO != ARR_RESUME)
    else $error("Start did not set the lock flag.");
  AST_START_BUSY: assert property (s_launch |=> busy_ff ##1 (busy_ff or s_halted))
    else $error("Start did not set bank busy.");
  AST_LOCK_TRAP: assert property ((REG_REQ.rd && lock_ff && REG_REQ.addr == fwcs_pkg::OFS_DAT0_L)
    |=> REG_TRAP && REG_RDATA == fwcs_pkg::INVALID)
    else $error("Locked data read did not trap.");
  AST_LOCK_NOWR: assert property ((REG_REQ.wr && lock_ff && REG_REQ.addr == fwcs_pkg::OFS_ADR_L)
    |=> $stable(adr_ff))
    else $error("Locked address write took effect.");
  AST_LOCK_VIS: assert property ((REG_REQ.rd && REG_REQ.addr == fwcs_pkg::OFS_CTL0_L)
    |=> !REG_TRAP && REG_RDATA[fwcs_pkg::BIT_LOCK] == $past(lock_ff))
    else $error("Lock flag read was not clean.");
  AST_ERR_HOLD: assert property ((busy_ff && !done) |=> err_ff == $past(err_ff))
    else $error("Error flag moved while busy.");
  AST_BANK_TRAP: assert property ((BANK_RD && busy_ff) |-> !BANK_RD_OK ##1 BANK_TRAP)
    else $error("Busy bank read did not trap.");
  AST_BANK_NOWR: assert property ((BANK_WR && busy_ff) |-> !BANK_WR_OK)
    else $error("Busy bank write was accepted.");
  AST_DONE_END: assert property ((done && state_ff == fwcs_pkg::ST_RUN)
    |=> s_halted ##0 ((sel_ff == fwcs_pkg::SEL_NONE) && (state_ff == fwcs_pkg::ST_IDLE)))
    else $error("Completion did not clear start, busy and select.");
  AST_SUSPEND_BIT_READ: assert property (suspend_bit_go
    |=> s_halted ##0 ((state_ff == fwcs_pkg::ST_SUSPEND_BIT) && suspend_bit_ff && ARR_SUSPEND))
    else $error("Suspend did not return the bank to read.");
  AST_ERR_REFUSE: assert property ((wr_ctl_h && wd[fwcs_pkg::BIT_START] && err_ff)
    |=> !ARR_GO && !ARR_RESUME)
    else $error("Start with error flag was accepted.");
  AST_PSUSP_ONLY: assert property ((start_req && state_ff == fwcs_pkg::ST_SUSPEND_BIT
    && suspend_bit_sel_ff != fwcs_pkg::SEL_SER && req_sel != suspend_bit_sel_ff)
    |=> state_ff == fwcs_pkg::ST_SUSPEND_BIT && sequence_error_flag_ff && !ARR_GO)
    else $error("Program suspend accepted a foreign operation.");
  AST_ESPGM_NOSUSP: assert property ((state_ff == fwcs_pkg::ST_ESPGM) |=> !ARR_SUSPEND)
    else $error("Program inside erase suspend was suspended.");
  AST_SPR_RANGE: assert property ((start_req && state_ff == fwcs_pkg::ST_IDLE
    && req_sel == fwcs_pkg::SEL_SPR && !in_prot) |=> sequence_error_flag_ff && !busy_ff)
    else $error("Out of range protection address not flagged.");
  AST_TEST_WR: assert property ((start_req && req_sel == fwcs_pkg::SEL_WPG && in_test)
    |=> !ARR_GO ##1 (!busy_ff || (state_ff != fwcs_pkg::ST_IDLE)))
    else $error("Program into the test area was launched.");

endmodule

// *** rtl/fwcs_pkg.sv ***
package fwcs_pkg;

  // Register offsets, byte addresses within the controller window.
  localparam logic [4:0] OFS_CTL0_L = 5'h00;
  localparam logic [4:0] OFS_CTL0_H = 5'h02;
  localparam logic [4:0] OFS_SECT_L = 5'h04;
  localparam logic [4:0] OFS_SECT_H = 5'h06;
  localparam logic [4:0] OFS_DAT0_L = 5'h08;
  localparam logic [4:0] OFS_DAT0_H = 5'h0A;
  localparam logic [4:0] OFS_DAT1_L = 5'h0C;
  localparam logic [4:0] OFS_DAT1_H = 5'h0E;
  localparam logic [4:0] OFS_ADR_L = 5'h10;
  localparam logic [4:0] OFS_ADR_H = 5'h12;
  localparam logic [4:0] OFS_ERR_L = 5'h14;

  // Field positions.
  localparam int BIT_BUSY = 1;
  localparam int BIT_LOCK = 4;
  localparam int BIT_START = 15;
  localparam int BIT_SUSPEND_BIT = 14;
  localparam int BIT_WPG = 13;
  localparam int BIT_DOUBLE_WORD_PROGRAM_SELECT = 12;
  localparam int BIT_SER = 11;
  localparam int BIT_SPR = 8;
  localparam int BIT_BANK_ST = 8;
  localparam int BIT_ERR = 0;
  localparam int BIT_SEQUENCE_ERROR_FLAG = 1;
  localparam int BE_LO = 0;
  localparam int BE_HI = 1;

  // Operation select codes, one bit per operation.
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_WPG = 4'h8;
  localparam logic [3:0] SEL_DOUBLE_WORD_PROGRAM_SELECT = 4'h4;
  localparam logic [3:0] SEL_SER = 4'h2;
  localparam logic [3:0] SEL_SPR = 4'h1;

  // Address ranges and codes.
  localparam logic [31:0] PROT_A = 32'h000E8FB0;
  localparam logic [31:0] PROT_B = 32'h0008DFBF;
  localparam logic [31:0] PROT_LO = (PROT_A < PROT_B) ? PROT_A : PROT_B;
  localparam logic [31:0] PROT_HI = (PROT_A < PROT_B) ? PROT_B : PROT_A;
  localparam logic [31:0] TEST_HI = 32'h00000FFF;
  localparam logic [15:0] TRAP_CODE = 16'h009B;
  localparam logic [15:0] INVALID = 16'hFFFF;

  // Reset values.
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN = 4'h2,
    ST_SUSPEND_BIT = 4'h4,
    ST_ESPGM = 4'h8
  } fwcs_state_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } fwcs_reg_req_s;

  typedef struct packed {
    logic [3:0] sel;
    logic [31:0] addr;
    logic [63:0] data;
    logic [7:0] sect;
  } fwcs_arr_cmd_s;

endpackage

// *** rtl/fwcs_sector_status.sv ***
module fwcs_sector_status #(
  parameter int NSECT = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software select and controller events
  input wire logic wr_en,
  input wire logic [NSECT-1:0] wdata,
  input wire logic erase_go,
  input wire logic end_ok,
  // Status
  output logic [NSECT-1:0] sect,
  output logic bank_st
);
  genvar i;
  generate
    for (i = 0; i < NSECT; i++) begin : g_sect
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sect[i] <= 1'b0;
        end else if (end_ok) begin
          sect[i] <= 1'b0;
        end else if (wr_en) begin
          sect[i] <= wdata[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bank_st <= 1'b0;
    end else if (end_ok) begin
      bank_st <= 1'b0;
    end else if (erase_go) begin
      bank_st <= 1'b1;
    end
  end
endmodule
